/* File: mocr_clock_regs.sv */
// Operation
// RL1 - Oscillator stays off while no honoured request is present.
// RL2 - Enable is OR of unconditional and honoured conditional requests.
// RL3 - Conditional requests count only while the enable bit is set.
// RL4 - Unconditional requests always enable the oscillator.
// RL5 - Flash controller requests only during write or erase.
// RL6 - Converter requests for whole conversion when using this oscillator.
// RL7 - New request while running leaves oscillator running, no restart.
// RL8 - Every register accepts word and byte accesses.
// RL9 - Even byte holds bits 7-0, odd byte holds bits 15-8.
// RL10 - Tap field in bits 12-8, reset zero, writable, loop adjusted.
// RL11 - Modulation counter in bits 7-3, reset zero, loop adjusted.
// RL12 - Counter wrap 31 to 0 increments tap field.
// RL13 - Counter wrap 0 to 31 decrements tap field.
// RL14 - Bits 15-13 and 2-0 read zero, ignore writes.
// RL15 - Tenth register optional, removed by build parameter.
// RL16 - Tap fault flag set while tap field is 0 or 31.
// RL17 - Tap and counter form one 10-bit up/down counter.
`timescale 1ns/1ps
`default_nettype none
`include "mocr_params.svh"

module mocr_clock_regs
   import mocr_pkg::*;
#(
   parameter bit HAS_EXTRA = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [4:0] wbAdr,
   input wire logic [1:0] wbSel,
   input wire logic [15:0] wbDatW,
   output logic [15:0] wbDatR,
   output logic wbAck,
   output logic wbErr,
   input wire logic [7:0] uncondReq,
   input wire logic [7:0] condReq,
   input wire logic loopUp,
   input wire logic loopDown,
   output logic moduleOscEnable,
   output logic tapFaultFlag
);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic [3:0] regIndex(input logic [4:0] adr);
      regIndex = 4'(adr[4:1]);
   endfunction : regIndex

   function automatic logic regValid(input logic [4:0] adr);
      regValid = (adr[4:1] < 4'd9) || (HAS_EXTRA && adr[4:1] == 4'd9);
   endfunction : regValid

   function automatic mocr_word_t resetVal(input int i);
      case (i)
         0: resetVal = `MOCR_RST_TAPMOD;
         1: resetVal = `MOCR_RST_RANGE;
         2: resetVal = `MOCR_RST_LOOPMD;
         3: resetVal = `MOCR_RST_REFSEL;
         4: resetVal = `MOCR_RST_SRCSEL;
         5: resetVal = `MOCR_RST_DIVSEL;
         6: resetVal = `MOCR_RST_XTAL;
         7: resetVal = `MOCR_RST_FAULT;
         8: resetVal = `MOCR_RST_REQCTL;
         default: resetVal = `MOCR_RST_EXTRA;
      endcase
   endfunction : resetVal

   mocr_state_s st_r;
   mocr_state_s st_nxt;
   mocr_word_t rd_r;
   mocr_word_t rd_nxt;
   logic err_r;
   logic err_nxt;
   logic [9:0] cnt;
   logic [9:0] cntNxt;
   logic req;
   logic [3:0] idx;
   mocr_word_t byteMask;

   // ----------------------------------------
   // Oscillator request combine
   // ----------------------------------------
   always_comb begin
      // RL3 conditional gating
      // RL4 unconditional always
      // RL2 one combined enable
      req = (|uncondReq) ||
         ((|condReq) && st_r.regs[8][`MOCR_REQEN_BIT]);
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      rd_nxt = rd_r;
      err_nxt = 1'b0;
      idx = regIndex(wbAdr);
      // RL9 byte lanes
      byteMask = {{8{wbSel[1]}}, {8{wbSel[0]}}};
      // RL1 off without request
      // RL7 stays on, no restart
      st_nxt.oscOn = req;
      // RL17 joint up/down counter
      cnt = {st_r.regs[0][`MOCR_TAP_HI:`MOCR_TAP_LO],
             st_r.regs[0][`MOCR_MOD_HI:`MOCR_MOD_LO]};
      cntNxt = cnt;
      // RL12 carry into tap
      if (loopUp && !loopDown) begin
         cntNxt = cnt + 10'h001;
      // RL13 borrow from tap
      end else if (loopDown && !loopUp) begin
         cntNxt = cnt - 10'h001;
      end
      // RL10 tap field
      // RL11 modulation counter
      st_nxt.regs[0] = {3'h0, cntNxt, 3'h0};
      case (st_r.bus)
         MOCR_IDLE: begin
            if (wbCyc && wbStb) begin
               st_nxt.bus = MOCR_ACK;
               // RL15 optional register
               if (!regValid(wbAdr)) begin
                  err_nxt = 1'b1;
                  rd_nxt = 16'h0000;
               end else if (wbWe) begin
                  // RL8 word or byte write
                  st_nxt.regs[idx] = (st_r.regs[idx] & ~byteMask) |
                     (wbDatW & byteMask);
                  // RL14 reserved bits zero
                  if (idx == 4'd0) begin
                     st_nxt.regs[0] = st_nxt.regs[0] & `MOCR_TAPMOD_MASK;
                  end
               end else begin
                  rd_nxt = st_r.regs[idx] & byteMask;
               end
            end
         end
         MOCR_ACK: begin
            st_nxt.bus = MOCR_IDLE;
         end
         default: begin
            st_nxt.bus = MOCR_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `MOCR_NREG; i++) begin
            st_r.regs[i] <= resetVal(i);
         end
         st_r.bus <= MOCR_IDLE;
         st_r.oscOn <= 1'b0;
         rd_r <= 16'h0000;
         err_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         rd_r <= rd_nxt;
         err_r <= err_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign wbAck = (st_r.bus == MOCR_ACK) && !err_r;
   assign wbErr = (st_r.bus == MOCR_ACK) && err_r;
   assign wbDatR = rd_r;
   assign moduleOscEnable = st_r.oscOn;
   // RL16 tap fault
   assign tapFaultFlag =
      (st_r.regs[0][`MOCR_TAP_HI:`MOCR_TAP_LO] == `MOCR_TAP_MIN) ||
      (st_r.regs[0][`MOCR_TAP_HI:`MOCR_TAP_LO] == `MOCR_TAP_MAX);

endmodule : mocr_clock_regs
`default_nettype wire

/* File: mocr_params.svh */
`ifndef MOCR_PARAMS_SVH
`define MOCR_PARAMS_SVH

// Register byte offsets
`define MOCR_OFF_TAPMOD 5'h00
`define MOCR_OFF_RANGE 5'h02
`define MOCR_OFF_LOOPMD 5'h04
`define MOCR_OFF_REFSEL 5'h06
`define MOCR_OFF_SRCSEL 5'h08
`define MOCR_OFF_DIVSEL 5'h0a
`define MOCR_OFF_XTAL 5'h0c
`define MOCR_OFF_FAULT 5'h0e
`define MOCR_OFF_REQCTL 5'h10
`define MOCR_OFF_EXTRA 5'h12

// Reset values
`define MOCR_RST_TAPMOD 16'h0000
`define MOCR_RST_RANGE 16'h0020
`define MOCR_RST_LOOPMD 16'h101f
`define MOCR_RST_REFSEL 16'h0000
`define MOCR_RST_SRCSEL 16'h0044
`define MOCR_RST_DIVSEL 16'h0000
`define MOCR_RST_XTAL 16'hc1cd
`define MOCR_RST_FAULT 16'h0703
`define MOCR_RST_REQCTL 16'h0707
`define MOCR_RST_EXTRA 16'h0000

// Field positions
`define MOCR_TAP_HI 12
`define MOCR_TAP_LO 8
`define MOCR_MOD_HI 7
`define MOCR_MOD_LO 3
`define MOCR_TAPMOD_MASK 16'h1ff8
`define MOCR_FAULT_TAP_BIT 1
`define MOCR_REQEN_BIT 4
`define MOCR_TAP_MIN 5'h00
`define MOCR_TAP_MAX 5'h1f
`define MOCR_NREG 10

`endif

/* File: mocr_pkg.sv */
package mocr_pkg;
   typedef logic [15:0] mocr_word_t;
   typedef enum logic [1:0] {MOCR_IDLE, MOCR_ACK} mocr_bus_e;
   typedef struct packed {
      mocr_word_t [9:0] regs;
      mocr_bus_e bus;
      logic oscOn;
   } mocr_state_s;
endpackage : mocr_pkg

/* File: mocr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module mocr_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbAck,
   input wire logic wbErr,
   input wire logic [7:0] uncondReq,
   input wire logic [7:0] condReq,
   input wire logic moduleOscEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence busReq;
      wbCyc && wbStb && !wbAck && !wbErr;
   endsequence
   sequence oscHeld;
      (moduleOscEnable && |uncondReq)[*2];
   endsequence
   chk_req_answer: assert property (busReq |=> wbAck || wbErr)
      else $error("bus request not answered");
   chk_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
      else $error("ack without request");
   chk_ack_pulse: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   chk_err_excl: assert property (wbErr |-> !wbAck ##1 !wbErr)
      else $error("err with ack or too long");
   chk_osc_off: assert property (!(|uncondReq) && !(|condReq) |=> !moduleOscEnable)
      else $error("oscillator on without request");
   chk_osc_uncond: assert property (|uncondReq |=> moduleOscEnable)
      else $error("unconditional request ignored");
   chk_osc_cause: assert property ($rose(moduleOscEnable) |-> $past(|uncondReq || |condReq))
      else $error("oscillator rose without request");
   chk_osc_steady: assert property (oscHeld |=> moduleOscEnable)
      else $error("oscillator restarted");
endmodule : mocr_monitor
`default_nettype wire

/* File: mocr_requesters.sv */
`timescale 1ns/1ps
`default_nettype none
module mocr_requesters (
   input wire logic clk,
   input wire logic flashOp,
   input wire logic convOp,
   input wire logic useOsc,
   output logic [1:0] req
);
   always_ff @(posedge clk) begin
      req[0] <= flashOp;
      req[1] <= convOp && useOsc;
   end
endmodule : mocr_requesters
`default_nettype wire

/* File: module_osc_request_and_clock_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mocr_params.svh"
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin n_errors++; $display("BAD %0t got %h want %h", $time, a, b); end end
module module_osc_request_and_clock_regs_tb;
   logic clk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, loopUp = 0, loopDown = 0, er;
   logic flashOp = 0, convOp = 0, useOsc = 0, wbAck, wbErr, moduleOscEnable, tapFaultFlag;
   logic [4:0] wbAdr = 0;
   logic [1:0] wbSel = 0, pReq;
   logic [15:0] wbDatW = 0, wbDatR, rd;
   logic [7:0] uncondReq, condReq = 0, extra = 0;
   int n_errors = 0, compares = 0, m[10], v;
   assign uncondReq = {extra[7:2], pReq};
   mocr_requesters mocr_requesters_i (.clk(clk), .flashOp(flashOp), .convOp(convOp),
      .useOsc(useOsc), .req(pReq));
   mocr_clock_regs mocr_clock_regs_i (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
      .wbAck(wbAck), .wbErr(wbErr), .uncondReq(uncondReq), .condReq(condReq),
      .loopUp(loopUp), .loopDown(loopDown), .moduleOscEnable(moduleOscEnable),
      .tapFaultFlag(tapFaultFlag));
   initial forever #50 clk = ~clk;
   task automatic close_out;
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic wb(input logic w, input logic [4:0] a, input logic [1:0] s,
      input logic [15:0] d);
      int k;
      k = 0;
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'h3, w, a, s, d};
      do begin
         @(posedge clk);
         k++;
      end while (!(wbAck || wbErr) && k < 9);
      rd = wbDatR;
      er = wbErr;
      {wbCyc, wbStb} <= 2'h0;
      if (k >= 9) begin
         n_errors++;
         close_out();
      end
   endtask : wb
   function automatic void mw(input int i, input logic [1:0] s, input logic [15:0] d);
      if (s[0]) m[i][7:0] = d[7:0];
      if (s[1]) m[i][15:8] = d[15:8];
      if (i == 0) m[0] &= `MOCR_TAPMOD_MASK;
   endfunction : mw
   task automatic rdc(input int i, input logic [1:0] s);
      wb(0, 5'(i * 2), s, 16'h0);
      `CHK(rd, 16'(m[i]) & {{8{s[1]}}, {8{s[0]}}})
   endtask : rdc
   task automatic step(input logic u);
      @(posedge clk);
      {loopUp, loopDown} <= {u, !u};
      @(posedge clk);
      {loopUp, loopDown} <= 2'h0;
      v = (m[0] >> 3) + (u ? 1 : 1023);
      m[0] = (v & 1023) << 3;
      rdc(0, 2'h3);
      `CHK(tapFaultFlag, 1'(m[0][12:8] == 0 || m[0][12:8] == 31))
   endtask : step
   initial begin
      v = $urandom(32'h1376);
      m = '{`MOCR_RST_TAPMOD, `MOCR_RST_RANGE, `MOCR_RST_LOOPMD, `MOCR_RST_REFSEL,
         `MOCR_RST_SRCSEL, `MOCR_RST_DIVSEL, `MOCR_RST_XTAL, `MOCR_RST_FAULT,
         `MOCR_RST_REQCTL, `MOCR_RST_EXTRA};
      repeat (20) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 10; i++) rdc(i, 2'h3);
      wb(0, 5'h14, 2'h3, 16'h0);
      `CHK(er, 1'b1)
      for (int i = 0; i < 10; i++) begin
         v = $urandom;
         wb(1, 5'(i * 2), v[1:0], v[31:16]);
         mw(i, v[1:0], v[31:16]);
         rdc(i, v[3:2]);
      end
      wb(1, 5'h0, 2'h3, 16'h01f8);
      mw(0, 2'h3, 16'h01f8);
      step(1);
      step(0);
      wb(1, 5'h0, 2'h3, 16'h0);
      mw(0, 2'h3, 16'h0);
      step(0);
      step(1);
      for (int k = 0; k < 16; k++) begin
         v = $urandom;
         wb(1, 5'h10, 2'h3, {11'h038, k > 7, 4'h7});
         mw(8, 2'h3, {11'h038, k > 7, 4'h7});
         {flashOp, convOp, useOsc} <= v[2:0];
         extra <= {v[8:3], 2'h0} & {8{v[9]}};
         condReq <= v[17:10];
         repeat (3) @(posedge clk);
         `CHK(moduleOscEnable, 1'(|uncondReq || (m[8][4] && |condReq)))
      end
      close_out();
   end
endmodule : module_osc_request_and_clock_regs_tb
bind mocr_clock_regs mocr_monitor mocr_monitor_i (.clk(clk), .rst(rst), .wbCyc(wbCyc),
   .wbStb(wbStb), .wbAck(wbAck), .wbErr(wbErr), .uncondReq(uncondReq), .condReq(condReq),
   .moduleOscEnable(moduleOscEnable));
`default_nettype wire
